// ---- rtl/fault_capture_pkg.sv ----
/*
  Constants, field layouts and carrier types for the recoverable fault capture block.
  Assumes a single 50 MHz clock domain and a plain one-cycle register port.
*/
// Notes on behaviour
// - Action code zero: a fault edge captures nothing and raises no flag.
// - Action 0x1: every fault edge captures the counter and flags each capture.
// - Action 0x2: capture only when counter is below stored value; flag each minimum.
// - Action 0x3: capture only when counter is above stored value; flag each maximum.
// - Action 0x4: always capture; flag only when a local minimum is seen.
// - Action 0x5: always capture; flag only when a local maximum is seen.
// - Action 0x6: always capture; flag on either local minimum or maximum.
// - Two-bit channel select routes captures to slot 0, 1, 2 or 3.
// - Halt field: code 0x0 no halt, code 0x1 halts the counter in hardware.
package fault_capture_pkg;

  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;
  localparam int COUNT_W = 16;
  localparam int SLOTS   = 4;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS   = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] MASK_OFS   = 8'h08;
  localparam logic [ADDR_W-1:0] COUNT_OFS  = 8'h0C;
  localparam logic [ADDR_W-1:0] SLOT0_OFS  = 8'h10;

  // Control field positions
  localparam int ACTION_LSB     = 0;
  localparam int COUNT_EN_BIT   = 3;
  localparam int COUNT_DOWN_BIT = 4;
  localparam int FAULT_EN_BIT   = 5;
  localparam int HALT_LSB       = 8;
  localparam int CAPTURE_CHANNEL_SELECT_LSB      = 10;

  // Status and mask bit positions
  localparam int FLAG_BIT = 0;
  localparam int PLAIN_CAPTURE_BIT = 1;
  localparam int HALT_BIT = 2;
  localparam int STAT_W   = 3;

  // Reset values
  localparam logic [DATA_W-1:0]  CTRL_RESET   = 32'h0000_0000;
  localparam logic [STAT_W-1:0]  STATUS_RESET = 3'h0;
  localparam logic [STAT_W-1:0]  MASK_RESET   = 3'h0;
  localparam logic [COUNT_W-1:0] COUNT_RESET  = 16'h0000;

  // Capture action codes
  localparam logic [2:0] ACT_DISABLE   = 3'h0;
  localparam logic [2:0] ACT_PLAIN     = 3'h1;
  localparam logic [2:0] ACT_IF_LOWER  = 3'h2;
  localparam logic [2:0] ACT_IF_HIGHER = 3'h3;
  localparam logic [2:0] ACT_LOC_MIN   = 3'h4;
  localparam logic [2:0] ACT_LOC_MAX   = 3'h5;
  localparam logic [2:0] ACT_EXTREMUM  = 3'h6;

  // Halt action codes
  localparam logic [1:0] HALT_NONE     = 2'h0;
  localparam logic [1:0] HALT_HARDWARE = 2'h1;

  typedef struct packed {
    logic [1:0] capture_channel_select;
    logic [1:0] halt_action;
    logic       fault_enable;
    logic       count_down;
    logic       count_enable;
    logic [2:0] capture_action;
  } ctrl_s;

  typedef struct packed {
    logic                     write;
    logic [$clog2(SLOTS)-1:0] index;
    logic [COUNT_W-1:0]       value;
  } slot_write_s;

  function automatic ctrl_s ctrl_unpack(input logic [DATA_W-1:0] w);
    ctrl_s c;
    c.capture_action         = w[ACTION_LSB +: 3];
    c.count_enable           = w[COUNT_EN_BIT];
    c.count_down             = w[COUNT_DOWN_BIT];
    c.fault_enable           = w[FAULT_EN_BIT];
    c.halt_action            = w[HALT_LSB +: 2];
    c.capture_channel_select = w[CAPTURE_CHANNEL_SELECT_LSB +: 2];
    return c;
  endfunction

  function automatic logic [DATA_W-1:0] ctrl_pack(input ctrl_s c);
    logic [DATA_W-1:0] w;
    w                      = '0;
    w[ACTION_LSB +: 3]     = c.capture_action;
    w[COUNT_EN_BIT]        = c.count_enable;
    w[COUNT_DOWN_BIT]      = c.count_down;
    w[FAULT_EN_BIT]        = c.fault_enable;
    w[HALT_LSB +: 2]       = c.halt_action;
    w[CAPTURE_CHANNEL_SELECT_LSB +: 2]      = c.capture_channel_select;
    return w;
  endfunction

endpackage

// ---- rtl/fault_edge_sync.sv ----
/*
  Two-flop synchroniser with rising edge detection for the fault pin.
  Assumes the pin is asynchronous to clk; output is in the clk domain.
*/
`timescale 1ns/100ps
module fault_edge_sync (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic ce,
  input  wire logic pin,
  output logic      level,
  output logic      rise
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } edge_state_s;

  edge_state_s state_q;
  edge_state_s state_d;

  always_comb begin
    state_d      = state_q;
    state_d.meta = pin;
    state_d.sync = state_q.meta;
    state_d.prev = state_q.sync;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= '0;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  assign level = state_q.sync;
  assign rise  = state_q.sync & ~state_q.prev;

endmodule // fault_edge_sync

// ---- rtl/capture_slot_bank.sv ----
/*
  Four capture/compare slots with one write port and full parallel readout.
  Assumes the writer resolves priority between hardware capture and software.
*/
`timescale 1ns/100ps
module capture_slot_bank
  import fault_capture_pkg::*;
#(
  parameter int WIDTH = COUNT_W
) (
  input  wire logic            clk,
  input  wire logic            resetn,
  input  wire logic            ce,
  input  wire slot_write_s     wr,
  output logic [WIDTH-1:0]     slot [SLOTS]
);

  typedef struct packed {
    logic [SLOTS-1:0][WIDTH-1:0] value;
  } bank_state_s;

  bank_state_s state_q;
  bank_state_s state_d;

  always_comb begin
    state_d = state_q;
    if (wr.write) begin
      state_d.value[wr.index] = wr.value[WIDTH-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= '0;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  always_comb begin
    for (int i = 0; i < SLOTS; i++) begin
      slot[i] = state_q.value[i];
    end
  end

endmodule // capture_slot_bank

// ---- rtl/recoverable_fault_capture.sv ----
/*
  Recoverable fault capture and halt logic beside a free-running counter.
  Holds control, sticky status, mask and counter registers behind a plain
  register port; read data appear the cycle after the read strobe.
  Assumes the fault pin is asynchronous and the register master is on clk.
*/
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/100ps
module recoverable_fault_capture
  import fault_capture_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr_strobe,
  input  wire logic              rd_strobe,
  output logic      [DATA_W-1:0] rdata,
  input  wire logic              fault_pin,
  output logic      [COUNT_W-1:0] count_value,
  output logic                   halted,
  output logic                   capture_strobe,
  output logic      [1:0]        capture_channel,
  output logic                   fault_capture_flag,
  output logic                   irq
);

  typedef struct packed {
    ctrl_s              ctrl;
    logic [STAT_W-1:0]  status;
    logic [STAT_W-1:0]  mask;
    logic [COUNT_W-1:0] count;
    logic               falling;
    logic               have_trend;
    logic               halt;
    logic               plain_capture_pulse;
    logic [1:0]         plain_capture_chan;
    logic [DATA_W-1:0]  rdata;
  } main_state_s;

  main_state_s state_q;
  main_state_s state_d;

  logic               fault_level;
  logic               fault_rise;
  logic [COUNT_W-1:0] slot [SLOTS];
  slot_write_s        slot_wr;

  // Decision signals of the current fault edge
  logic               edge_valid;
  logic [COUNT_W-1:0] last_value;
  logic               is_lower;
  logic               is_higher;
  logic               local_min;
  logic               local_max;
  logic               do_capture;
  logic               do_flag;
  logic               do_halt;
  logic [STAT_W-1:0]  status_set;
  logic [STAT_W-1:0]  status_clr;

  fault_edge_sync u_sync (
    .clk    (clk),
    .resetn (resetn),
    .ce     (ce),
    .pin    (fault_pin),
    .level  (fault_level),
    .rise   (fault_rise)
  );

  capture_slot_bank #(
    .WIDTH (COUNT_W)
  ) u_bank (
    .clk    (clk),
    .resetn (resetn),
    .ce     (ce),
    .wr     (slot_wr),
    .slot   (slot)
  );

  function automatic logic is_slot_addr(input logic [ADDR_W-1:0] a);
    return (a >= SLOT0_OFS) && (a < SLOT0_OFS + ADDR_W'(4 * SLOTS)) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [1:0] slot_index(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] rel;
    rel = a - SLOT0_OFS;
    return rel[3:2];
  endfunction

  function automatic logic [DATA_W-1:0] widen(input logic [COUNT_W-1:0] v);
    return {{(DATA_W - COUNT_W){1'b0}}, v};
  endfunction

  // Qualify the edge and compare with the selected slot's last value
  always_comb begin
    edge_valid = fault_rise & state_q.ctrl.fault_enable;
    last_value = slot[state_q.ctrl.capture_channel_select];
    is_lower   = state_q.count < last_value;
    is_higher  = state_q.count > last_value;
    // A turn from falling to rising marks a minimum, and the reverse a maximum
    local_min  = state_q.have_trend & state_q.falling & is_higher;
    local_max  = state_q.have_trend & ~state_q.falling & is_lower;
  end

  // Capture and flag decision per action code
  always_comb begin
    do_capture = 1'b0;
    do_flag    = 1'b0;
    case (state_q.ctrl.capture_action)
      ACT_DISABLE: begin
        do_capture = 1'b0;
        do_flag    = 1'b0;
      end
      ACT_PLAIN: begin
        do_capture = edge_valid;
        do_flag    = edge_valid;
      end
      ACT_IF_LOWER: begin
        do_capture = edge_valid & is_lower;
        do_flag    = edge_valid & is_lower;
      end
      ACT_IF_HIGHER: begin
        do_capture = edge_valid & is_higher;
        do_flag    = edge_valid & is_higher;
      end
      ACT_LOC_MIN: begin
        do_capture = edge_valid;
        do_flag    = edge_valid & local_min;
      end
      ACT_LOC_MAX: begin
        do_capture = edge_valid;
        do_flag    = edge_valid & local_max;
      end
      ACT_EXTREMUM: begin
        do_capture = edge_valid;
        do_flag    = edge_valid & (local_min | local_max);
      end
      default: begin
        do_capture = 1'b0;
        do_flag    = 1'b0;
      end
    endcase
  end

  // Only the hardware code halts; other codes leave the counter running
  assign do_halt = edge_valid && (state_q.ctrl.halt_action == HALT_HARDWARE);

  // Slot write port: hardware capture wins over a software write
  always_comb begin
    slot_wr = '0;
    if (do_capture) begin
      slot_wr.write = 1'b1;
      slot_wr.index = state_q.ctrl.capture_channel_select;
      slot_wr.value = state_q.count;
    end else if (wr_strobe && is_slot_addr(addr)) begin
      slot_wr.write = 1'b1;
      slot_wr.index = slot_index(addr);
      slot_wr.value = wdata[COUNT_W-1:0];
    end
  end

  always_comb begin
    status_set           = '0;
    status_set[FLAG_BIT] = do_flag;
    status_set[PLAIN_CAPTURE_BIT] = do_capture;
    status_set[HALT_BIT] = do_halt;
    status_clr           = '0;
    if (wr_strobe && (addr == STATUS_OFS)) begin
      status_clr = wdata[STAT_W-1:0];
    end
  end

  always_comb begin
    state_d = state_q;

    // Register writes
    if (wr_strobe) begin
      case (addr)
        CTRL_OFS:  state_d.ctrl = ctrl_unpack(wdata);
        MASK_OFS:  state_d.mask = wdata[STAT_W-1:0];
        default:   state_d.ctrl = state_q.ctrl;
      endcase
    end

    // Sticky status: a new event wins over a clear in the same cycle
    state_d.status = (state_q.status & ~status_clr) | status_set;

    // Hardware halt holds while the fault level stays high
    if (do_halt) begin
      state_d.halt = 1'b1;
    end else if (!fault_level || (state_q.ctrl.halt_action != HALT_HARDWARE)) begin
      state_d.halt = 1'b0;
    end

    // Counter: software write, else count when count_enable is set and not halted
    if (wr_strobe && (addr == COUNT_OFS)) begin
      state_d.count = wdata[COUNT_W-1:0];
    end else if (state_q.ctrl.count_enable && !state_q.halt) begin
      if (state_q.ctrl.count_down) begin
        state_d.count = state_q.count - COUNT_W'(1);
      end else begin
        state_d.count = state_q.count + COUNT_W'(1);
      end
    end

    // Trend between successive captures feeds extremum detection
    if (do_capture) begin
      if (is_lower) begin
        state_d.falling    = 1'b1;
        state_d.have_trend = 1'b1;
      end else if (is_higher) begin
        state_d.falling    = 1'b0;
        state_d.have_trend = 1'b1;
      end
    end

    state_d.plain_capture_pulse = do_capture;
    if (do_capture) begin
      state_d.plain_capture_chan = state_q.ctrl.capture_channel_select;
    end

    // Read data stand only in the cycle after the strobe
    state_d.rdata = '0;
    if (rd_strobe) begin
      if (addr == CTRL_OFS) begin
        state_d.rdata = ctrl_pack(state_q.ctrl);
      end else if (addr == STATUS_OFS) begin
        state_d.rdata = {{(DATA_W - STAT_W){1'b0}}, state_q.status};
      end else if (addr == MASK_OFS) begin
        state_d.rdata = {{(DATA_W - STAT_W){1'b0}}, state_q.mask};
      end else if (addr == COUNT_OFS) begin
        state_d.rdata = widen(state_q.count);
      end else if (is_slot_addr(addr)) begin
        state_d.rdata = widen(slot[slot_index(addr)]);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q            <= '0;
      state_q.ctrl       <= ctrl_unpack(CTRL_RESET);
      state_q.status     <= STATUS_RESET;
      state_q.mask       <= MASK_RESET;
      state_q.count      <= COUNT_RESET;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  assign rdata              = state_q.rdata;
  assign count_value        = state_q.count;
  assign halted             = state_q.halt;
  assign capture_strobe     = state_q.plain_capture_pulse;
  assign capture_channel    = state_q.plain_capture_chan;
  assign fault_capture_flag = state_q.status[FLAG_BIT];
  assign irq                = |(state_q.status & state_q.mask);

endmodule // recoverable_fault_capture

// ---- test/fault_source.sv ----
/*
  Behavioural source of recoverable fault pulses for the capture block.
  Assumes fire is a one-cycle request on clk; each pulse is 6 cycles high, then at least 7 low.
*/
`timescale 1ns/100ps
module fault_source (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic fire,
  output logic      pin
);
  logic [3:0] left_q;
  // Low time keeps separate pulses apart for the pin synchroniser
  always @(posedge clk) begin
    if (!resetn) begin
      left_q <= 4'h0;
      pin    <= 1'b0;
    end else if (fire && left_q == 4'h0) begin
      left_q <= 4'hC;
      pin    <= 1'b1;
    end else if (left_q != 4'h0) begin
      left_q <= left_q - 4'h1;
      pin    <= (left_q > 4'h7);
    end
  end
endmodule // fault_source

// ---- test/recoverable_fault_capture_chk.sv ----
/*
  Port-level assertions for the recoverable fault capture block.
  Assumes ce high and a fault pin held steady for at least three cycles.
*/
`timescale 1ns/100ps
module recoverable_fault_capture_chk
  import fault_capture_pkg::*;
(
  input wire logic               clk,
  input wire logic               resetn,
  input wire logic               ce,
  input wire logic [ADDR_W-1:0]  addr,
  input wire logic [DATA_W-1:0]  wdata,
  input wire logic               wr_strobe,
  input wire logic               rd_strobe,
  input wire logic [DATA_W-1:0]  rdata,
  input wire logic               fault_pin,
  input wire logic [COUNT_W-1:0] count_value,
  input wire logic               halted,
  input wire logic               capture_strobe,
  input wire logic [1:0]         capture_channel,
  input wire logic               fault_capture_flag,
  input wire logic               irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_strobe_pulse; capture_strobe |=> !capture_strobe; endproperty
  property p_read_idle; ce && !rd_strobe |=> rdata == '0; endproperty
  property p_flag_cause; $rose(fault_capture_flag) |-> capture_strobe; endproperty
  property p_plain_capture_cause; capture_strobe |-> $past(fault_pin, 2) && $past(fault_pin, 3);
  endproperty
  property p_halt_cause; $rose(halted) |-> $past(fault_pin, 2) && $past(fault_pin, 3);
  endproperty
  property p_count_frozen; halted |=> $stable(count_value); endproperty
  property p_chan_cause; $changed(capture_channel) |-> ##[0:1] capture_strobe; endproperty
  property p_flag_sticky; fault_capture_flag && !wr_strobe |=> fault_capture_flag; endproperty
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("long capture strobe");
  a_read_idle: assert property (p_read_idle) else $error("read data without read");
  a_flag_cause: assert property (p_flag_cause) else $error("flag without capture");
  a_plain_capture_cause: assert property (p_plain_capture_cause) else $error("capture without fault");
  a_halt_cause: assert property (p_halt_cause) else $error("halt without fault");
  a_count_frozen: assert property (p_count_frozen) else $error("count moved in halt");
  a_chan_cause: assert property (p_chan_cause) else $error("channel moved alone");
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");
  c_capture: cover property (capture_strobe);
  c_slot3: cover property (capture_strobe && capture_channel == 2'h3);
  c_halt: cover property ($rose(halted));
  c_irq: cover property ($rose(irq));
endmodule // recoverable_fault_capture_chk

bind recoverable_fault_capture recoverable_fault_capture_chk i_chk (.clk(clk), .resetn(resetn),
  .ce(ce), .addr(addr), .wdata(wdata), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
  .rdata(rdata), .fault_pin(fault_pin), .count_value(count_value), .halted(halted),
  .capture_strobe(capture_strobe), .capture_channel(capture_channel),
  .fault_capture_flag(fault_capture_flag), .irq(irq));

// ---- test/recoverable_fault_capture_test.sv ----
/*
  Self-checking bench: register tasks, a fault pulse source and a table of captures.
  Assumes one 50 MHz clock; ce held high except for a five-cycle freeze during the count check.
*/
`timescale 1ns/100ps
module recoverable_fault_capture_test;
  import fault_capture_pkg::*;
  typedef struct packed {
    logic [1:0]  ch;
    logic [2:0]  act;
    logic [15:0] cnt;
    logic [15:0] slot;
    logic        flag;
  } step_s;
  logic               clk       = 1'b0;
  logic               resetn    = 1'b0;
  logic               ce        = 1'b1;
  logic [ADDR_W-1:0]  addr      = '0;
  logic [DATA_W-1:0]  wdata     = '0;
  logic               wr_strobe = 1'b0;
  logic               rd_strobe = 1'b0;
  logic               fire      = 1'b0;
  logic               fault_pin;
  logic [COUNT_W-1:0] count_value;
  logic               halted, capture_strobe, fault_capture_flag, irq, seen_halt, seen_strobe;
  logic [1:0]         capture_channel;
  logic [DATA_W-1:0]  rdata, rv;
  int                 n_fail    = 0;
  int                 cmp_count = 0;
  // Flag x: trend before this step is not pinned down, flag not compared
  step_s steps [17] = '{
    '{2'h0, 3'h1, 16'h0010, 16'h0010, 1'b1}, '{2'h1, 3'h1, 16'h0011, 16'h0011, 1'b1},
    '{2'h2, 3'h1, 16'h0012, 16'h0012, 1'b1}, '{2'h3, 3'h1, 16'h0013, 16'h0013, 1'b1},
    '{2'h0, 3'h2, 16'h0020, 16'h0010, 1'b0}, '{2'h0, 3'h2, 16'h0008, 16'h0008, 1'b1},
    '{2'h1, 3'h3, 16'h0009, 16'h0011, 1'b0}, '{2'h1, 3'h3, 16'h0030, 16'h0030, 1'b1},
    '{2'h2, 3'h4, 16'h0050, 16'h0050, 1'bx}, '{2'h2, 3'h4, 16'h0040, 16'h0040, 1'b0},
    '{2'h2, 3'h4, 16'h0045, 16'h0045, 1'b1}, '{2'h2, 3'h5, 16'h0030, 16'h0030, 1'b1},
    '{2'h2, 3'h5, 16'h0020, 16'h0020, 1'b0}, '{2'h2, 3'h6, 16'h0028, 16'h0028, 1'b1},
    '{2'h2, 3'h6, 16'h0038, 16'h0038, 1'b0}, '{2'h2, 3'h6, 16'h0033, 16'h0033, 1'b1},
    '{2'h3, 3'h0, 16'h0077, 16'h0013, 1'b0}};
  always #10 clk = ~clk;
  recoverable_fault_capture i_dut (.clk(clk), .resetn(resetn), .ce(ce), .addr(addr),
    .wdata(wdata), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata),
    .fault_pin(fault_pin), .count_value(count_value), .halted(halted),
    .capture_strobe(capture_strobe), .capture_channel(capture_channel),
    .fault_capture_flag(fault_capture_flag), .irq(irq));
  fault_source i_src (.clk(clk), .resetn(resetn), .fire(fire), .pin(fault_pin));
  task automatic chk(input string what, input logic [DATA_W-1:0] seen,
                     input logic [DATA_W-1:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    addr      <= a;
    wdata     <= d;
    wr_strobe <= 1'b1;
    @(posedge clk);
    wr_strobe <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    addr      <= a;
    rd_strobe <= 1'b1;
    @(posedge clk);
    rd_strobe <= 1'b0;
    @(negedge clk);
    d = rdata;
    @(posedge clk);
  endtask
  task automatic fault();
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    seen_halt = 1'b0;
    seen_strobe = 1'b0;
    repeat (14) begin
      @(posedge clk);
      seen_halt |= halted;
      seen_strobe |= capture_strobe;
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #1000000;
    n_fail++;
    wrap_up();
  end
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd(CTRL_OFS, rv);
    chk("ctrl reset", rv, CTRL_RESET);
    rd(STATUS_OFS, rv);
    chk("status reset", rv, 32'(STATUS_RESET));
    rd(MASK_OFS, rv);
    chk("mask reset", rv, 32'(MASK_RESET));
    rd(8'h40, rv);
    chk("unmapped read", rv, 32'h0000_0000);
    steps[16].act = 3'h0;
    for (int k = 0; k < 18; k++) begin
      int i;
      i = (k == 17) ? 16 : k;
      if (k == 17) steps[16].act = 3'h7;
      wr(CTRL_OFS, (32'(steps[i].ch) << CAPTURE_CHANNEL_SELECT_LSB) | 32'h0000_0020 | 32'(steps[i].act));
      wr(COUNT_OFS, 32'(steps[i].cnt));
      wr(STATUS_OFS, 32'h0000_0007);
      fault();
      chk("no halt", seen_halt, 1'b0);
      rd(SLOT0_OFS + 8'(4 * steps[i].ch), rv);
      chk("slot", rv, 32'(steps[i].slot));
      rd(STATUS_OFS, rv);
      if (steps[i].flag === 1'bx) rv[0] = 1'b0;
      chk("status", rv, {30'h0, steps[i].slot == steps[i].cnt, steps[i].flag === 1'b1});
      if (steps[i].slot == steps[i].cnt) chk("channel", capture_channel, steps[i].ch);
      chk("strobe", seen_strobe, steps[i].slot == steps[i].cnt);
    end
    chk("count pin", count_value, 32'h0000_0077);
    wr(CTRL_OFS, 32'h0000_0008);
    wr(COUNT_OFS, 32'h0000_0100);
    ce <= 1'b0;
    repeat (5) @(posedge clk);
    ce <= 1'b1;
    rd(COUNT_OFS, rv);
    chk("count up frozen", rv, 32'h0000_0101);
    wr(CTRL_OFS, 32'h0000_0018);
    wr(COUNT_OFS, 32'h0000_0100);
    rd(COUNT_OFS, rv);
    chk("count down", rv, 32'h0000_00FF);
    wr(STATUS_OFS, 32'h0000_0007);
    wr(MASK_OFS, 32'h0000_0001);
    wr(CTRL_OFS, 32'h0000_0129);
    fault();
    chk("halt seen", seen_halt, 1'b1);
    chk("halt strobe", seen_strobe, 1'b1);
    chk("irq raised", irq, 1'b1);
    rd(STATUS_OFS, rv);
    chk("halt status", rv, 32'h0000_0007);
    wr(MASK_OFS, 32'h0000_0000);
    chk("irq masked", irq, 1'b0);
    wr(MASK_OFS, 32'h0000_0001);
    chk("irq unmasked", irq, 1'b1);
    wr(STATUS_OFS, 32'h0000_0007);
    chk("irq cleared", irq, 1'b0);
    rd(STATUS_OFS, rv);
    chk("status cleared", rv, 32'h0000_0000);
    wrap_up();
  end
endmodule // recoverable_fault_capture_test
